// File: rssd_datapath.sv
// rotate, subtract and sleep datapath of the 8-bit core
`timescale 1ns/10ps
module rssd_datapath #(
   parameter int WDT_W = rssd_pkg::WDT_W,
   parameter int PRE_W = rssd_pkg::PRE_W
) (
   // clock and reset
   input  wire logic                          clk_in,
   input  wire logic                          rstn_in,
   // instruction issue, one cycle each
   input  wire logic [rssd_pkg::OP_W-1:0]     op_in,
   input  wire logic                          dest_in,
   input  wire logic [rssd_pkg::ADDR_W-1:0]   addr_in,
   input  wire logic [rssd_pkg::DATA_W-1:0]   literal_in,
   input  wire logic [rssd_pkg::DATA_W-1:0]   reg_data_in,
   // wake from sleep
   input  wire logic                          wake_in,
   // register file write back
   output logic                               reg_we_out,
   output logic      [rssd_pkg::ADDR_W-1:0]   reg_addr_out,
   output logic      [rssd_pkg::DATA_W-1:0]   reg_wdata_out,
   // architectural state
   output logic      [rssd_pkg::DATA_W-1:0]   acc_out,
   output logic                               carry_out,
   output logic                               nibble_carry_out,
   output logic                               zero_out,
   output logic                               timeout_flag_out,
   output logic                               power_down_flag_out,
   output logic      [WDT_W-1:0]              watchdog_counter_out,
   output logic      [PRE_W-1:0]              prescaler_out,
   // power
   output logic                               osc_run_out,
   output logic                               sleeping_out
);
   if (WDT_W < 1 || PRE_W < 1)
   begin : g_bad_width
      $error("rssd_datapath: counter widths must be positive");
   end

   // reset released through two flops
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // wake pin synchroniser; only the second flop is read
   logic wake_meta;
   logic wake_sync;
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
      end
      else
      begin
         wake_meta <= wake_in;
         wake_sync <= wake_meta;
      end
   end

   typedef enum logic [1:0] {RUN, SLEEP_ENTER, ASLEEP} rssd_pwr_type;
   rssd_pwr_type pwr;
   rssd_pwr_type next_pwr;

   // instructions are ignored unless running
   wire logic running;
   wire logic is_rot;
   wire logic is_lit;
   wire logic is_reg;
   wire logic is_sbb;
   wire logic is_sub;
   wire logic is_sleep;
   assign running  = (pwr == RUN);
   assign is_rot   = running && (op_in == rssd_pkg::OP_ROTATE);
   assign is_lit   = running && (op_in == rssd_pkg::OP_LITSUB);
   assign is_reg   = running && (op_in == rssd_pkg::OP_REGSUB);
   assign is_sbb   = running && (op_in == rssd_pkg::OP_REGSBB);
   assign is_sub   = is_lit || is_reg || is_sbb;
   assign is_sleep = running && (op_in == rssd_pkg::OP_SLEEP);

   // subtract operands: literal or register minus accumulator
   wire logic [7:0] sub_a;
   wire logic       sub_borrow;
   wire logic [7:0] sub_diff;
   wire logic       sub_c;
   wire logic       sub_dc;
   wire logic       sub_z;
   assign sub_a      = is_lit ? literal_in : reg_data_in;
   assign sub_borrow = is_sbb ? ~carry_out : 1'b0;

   rssd_sub #(
      .WIDTH(rssd_pkg::DATA_W)
   ) u_sub (
      .a_in      (sub_a),
      .b_in      (acc_out),
      .borrow_in (sub_borrow),
      .diff_out  (sub_diff),
      .carry_out (sub_c),
      .nibble_out(sub_dc),
      .zero_out  (sub_z)
   );

   wire logic [7:0] rot_val;
   assign rot_val = {carry_out, reg_data_in[7:1]};

   wire logic [7:0] result;
   wire logic       to_reg;
   wire logic       to_acc;
   assign result = is_rot ? rot_val : sub_diff;
   assign to_reg = (is_rot || is_reg || is_sbb) && (dest_in == rssd_pkg::DEST_REG);
   assign to_acc = is_lit ||
                   ((is_rot || is_reg || is_sbb) && (dest_in == rssd_pkg::DEST_ACC));

   wire logic wdt_tick;
   assign wdt_tick = running && (op_in == rssd_pkg::OP_WDTTCK);

   always_comb
   begin
      next_pwr = pwr;
      unique case (pwr)
         RUN:         if (is_sleep) next_pwr = SLEEP_ENTER;
         SLEEP_ENTER: next_pwr = ASLEEP;
         ASLEEP:      if (wake_sync) next_pwr = RUN;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pwr <= RUN;
      end
      else
      begin
         pwr <= next_pwr;
      end
   end

   // datapath results and status
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_out          <= rssd_pkg::RST_ACC;
         carry_out        <= rssd_pkg::RST_CARRY;
         nibble_carry_out <= rssd_pkg::RST_NIBBLE;
         zero_out         <= rssd_pkg::RST_ZERO;
         reg_we_out       <= 1'b0;
         reg_addr_out     <= '0;
         reg_wdata_out    <= '0;
      end
      else
      begin
         reg_we_out    <= to_reg;
         reg_addr_out  <= addr_in;
         reg_wdata_out <= result;
         if (to_acc)
            acc_out <= result;
         if (is_rot)
            carry_out <= reg_data_in[0];
         else if (is_sub)
            carry_out <= sub_c;
         if (is_sub)
         begin
            nibble_carry_out <= sub_dc;
            zero_out         <= sub_z;
         end
      end
   end

   // watchdog, prescaler and power flags
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timeout_flag_out     <= rssd_pkg::RST_TIMEOUT;
         power_down_flag_out  <= rssd_pkg::RST_PWRDOWN;
         watchdog_counter_out <= '0;
         prescaler_out        <= '0;
      end
      else if (is_sleep)
      begin
         timeout_flag_out     <= 1'b1;
         power_down_flag_out  <= 1'b0;
         watchdog_counter_out <= '0;
         prescaler_out        <= '0;
      end
      else if (wdt_tick)
      begin
         // prescaler carries into the counter on rollover
         prescaler_out <= prescaler_out + PRE_W'(1);
         if (&prescaler_out)
            watchdog_counter_out <= watchdog_counter_out + WDT_W'(1);
      end
   end

   // oscillator stops once the flag updates have landed
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         osc_run_out  <= 1'b1;
         sleeping_out <= 1'b0;
      end
      else
      begin
         osc_run_out  <= (next_pwr != ASLEEP);
         sleeping_out <= (next_pwr != RUN);
      end
   end

   // checks
   rotate_carry_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      is_rot |=> carry_out == $past(reg_data_in[0]))
      else $error("rotate carry wrong");
   rotate_bit7_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      is_rot && dest_in |=> reg_wdata_out == {$past(carry_out), $past(reg_data_in[7:1])}
      && reg_we_out)
      else $error("rotate result wrong");
   rotate_flags_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      is_rot |=> $stable(zero_out) && $stable(nibble_carry_out))
      else $error("rotate touched other flags");
   dest_acc_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      (is_reg || is_sbb) && !dest_in |=> !reg_we_out && acc_out ==
      8'($past(reg_data_in) - $past(acc_out) - {7'h00, $past(is_sbb) & ~$past(carry_out)}))
      else $error("destination acc wrong");
   lit_sub_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      is_lit |=> acc_out == 8'($past(literal_in) - $past(acc_out)) && !reg_we_out)
      else $error("literal subtract wrong");
   lit_carry_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      is_lit |=> carry_out == ($past(acc_out) <= $past(literal_in)) &&
      nibble_carry_out == ($past(acc_out[3:0]) <= $past(literal_in[3:0])))
      else $error("literal carry wrong");
   reg_carry_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      is_reg |=> carry_out == ($past(acc_out) <= $past(reg_data_in)))
      else $error("register carry wrong");
   borrow_sub_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      is_sbb && dest_in |=> reg_wdata_out ==
      8'($past(reg_data_in) - $past(acc_out) - {7'h00, ~$past(carry_out)}))
      else $error("borrow subtract wrong");
   zero_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      is_sub |=> zero_out == ((reg_we_out ? reg_wdata_out : acc_out) == 8'h00))
      else $error("zero flag wrong");
   sleep_flags_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      is_sleep |=> timeout_flag_out && !power_down_flag_out &&
      watchdog_counter_out == '0 && prescaler_out == '0)
      else $error("sleep flags wrong");
   sleep_osc_a: assert property (@(posedge clk_in) disable iff (!rst_n)
      is_sleep |=> osc_run_out ##1 !osc_run_out)
      else $error("oscillator not halted");

   rotate_c: cover property (@(posedge clk_in) disable iff (!rst_n) is_rot && dest_in);
   borrow_c: cover property (@(posedge clk_in) disable iff (!rst_n) is_sbb && !carry_out);
   sleep_c:  cover property (@(posedge clk_in) disable iff (!rst_n)
      is_sleep ##2 !osc_run_out ##[1:20] osc_run_out);
endmodule : rssd_datapath

// File: rssd_pkg.sv
// package: opcodes, destination bit codes, reset values and widths for the datapath
package rssd_pkg;
   localparam int DATA_W      = 8;
   localparam int ADDR_W      = 7;
   localparam int WDT_W       = 8;
   localparam int PRE_W       = 8;
   localparam int OP_W        = 3;
   // operation codes on op_in
   localparam logic [2:0] OP_NONE   = 3'h0;
   localparam logic [2:0] OP_ROTATE = 3'h1;
   localparam logic [2:0] OP_LITSUB = 3'h2;
   localparam logic [2:0] OP_REGSUB = 3'h3;
   localparam logic [2:0] OP_REGSBB = 3'h4;
   localparam logic [2:0] OP_SLEEP  = 3'h5;
   localparam logic [2:0] OP_WDTTCK = 3'h6;
   // destination bit
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_REG = 1'b1;
   // status bits and accumulator after reset
   localparam logic RST_CARRY   = 1'b0;
   localparam logic RST_NIBBLE  = 1'b0;
   localparam logic RST_ZERO    = 1'b0;
   localparam logic RST_TIMEOUT = 1'b1;
   localparam logic RST_PWRDOWN = 1'b1;
   localparam logic [7:0] RST_ACC = 8'h00;
endpackage : rssd_pkg

// File: rssd_sub.sv
// subtractor: a - b - borrow with carry, nibble carry and zero
`timescale 1ns/10ps
module rssd_sub #(
   parameter int WIDTH = 8
) (
   // operands
   input  wire logic [WIDTH-1:0] a_in,
   input  wire logic [WIDTH-1:0] b_in,
   input  wire logic             borrow_in,
   // result
   output logic      [WIDTH-1:0] diff_out,
   output logic                  carry_out,
   output logic                  nibble_out,
   output logic                  zero_out
);
   if (WIDTH < 5)
   begin : g_bad_width
      $error("rssd_sub: width must exceed a nibble");
   end

   // carry is the inverted borrow: a + ~b + ~borrow
   wire logic [WIDTH:0] full_sum;
   wire logic [4:0]     low_sum;
   assign full_sum   = {1'b0, a_in} + {1'b0, ~b_in} + {{WIDTH{1'b0}}, ~borrow_in};
   assign low_sum    = {1'b0, a_in[3:0]} + {1'b0, ~b_in[3:0]} + {4'h0, ~borrow_in};
   assign diff_out   = full_sum[WIDTH-1:0];
   assign carry_out  = full_sum[WIDTH];
   assign nibble_out = low_sum[4];
   assign zero_out   = (full_sum[WIDTH-1:0] == '0);
endmodule : rssd_sub

// File: rssd_datapath_bench.sv
// self-checking bench for the rotate, subtract and sleep datapath
`timescale 1ns/10ps
module rssd_datapath_bench;
   logic       clk_in = 1'b0;
   logic       rstn_in = 1'b0;
   logic [2:0] op_in = 3'h0;
   logic       dest_in = 1'b0;
   logic [6:0] addr_in = 7'h00;
   logic [7:0] literal_in = 8'h00;
   logic [7:0] reg_data_in = 8'h00;
   logic       wake_in = 1'b0;
   logic       reg_we_out;
   logic [6:0] reg_addr_out;
   logic [7:0] reg_wdata_out;
   logic [7:0] acc_out;
   logic       carry_out;
   logic       nibble_carry_out;
   logic       zero_out;
   logic       timeout_flag_out;
   logic       power_down_flag_out;
   logic [7:0] watchdog_counter_out;
   logic [7:0] prescaler_out;
   logic       osc_run_out;
   logic       sleeping_out;
   int         n_errors = 0;
   int         n_tests = 0;
   // reference state kept apart from the design
   logic [7:0] m_acc = 8'h00;
   logic       m_c = 1'b0;
   logic       m_dc = 1'b0;
   logic       m_z = 1'b0;
   // sequence walks flag edges: equal operands, borrow in, nibble borrow, zero rotate
   logic [2:0] t_op [16] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h3,
                             3'h3, 3'h4, 3'h3, 3'h4, 3'h3, 3'h4, 3'h4, 3'h1};
   logic       t_dst [16] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
                              1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
   logic [7:0] t_lit [16] = '{8'h35, 8'h35, 8'h10, 8'h08, 8'hf0, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] t_reg [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h02, 8'h05,
                             8'h40, 8'h00, 8'h07, 8'h07, 8'h03, 8'hfc, 8'h00, 8'h01};

   always #5 clk_in = ~clk_in;

   rssd_datapath i_dut (
      .clk_in               (clk_in),
      .rstn_in              (rstn_in),
      .op_in                (op_in),
      .dest_in              (dest_in),
      .addr_in              (addr_in),
      .literal_in           (literal_in),
      .reg_data_in          (reg_data_in),
      .wake_in              (wake_in),
      .reg_we_out           (reg_we_out),
      .reg_addr_out         (reg_addr_out),
      .reg_wdata_out        (reg_wdata_out),
      .acc_out              (acc_out),
      .carry_out            (carry_out),
      .nibble_carry_out     (nibble_carry_out),
      .zero_out             (zero_out),
      .timeout_flag_out     (timeout_flag_out),
      .power_down_flag_out  (power_down_flag_out),
      .watchdog_counter_out (watchdog_counter_out),
      .prescaler_out        (prescaler_out),
      .osc_run_out          (osc_run_out),
      .sleeping_out         (sleeping_out)
   );

   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task give_verdict;
      if (n_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   // issue one op, then compare with the reference one cycle later
   task run_op(input logic [2:0] op, input logic dst, input logic [7:0] lit,
               input logic [7:0] rv, input logic [6:0] ad);
      logic [8:0] d9;
      logic [4:0] d5;
      logic       bw;
      logic [7:0] res;
      logic       we;
      bw = (op == rssd_pkg::OP_REGSBB) ? ~m_c : 1'b0;
      if (op == rssd_pkg::OP_LITSUB)
      begin
         d9 = {1'b0, lit} - {1'b0, m_acc};
         d5 = {1'b0, lit[3:0]} - {1'b0, m_acc[3:0]};
      end
      else
      begin
         d9 = {1'b0, rv} - {1'b0, m_acc} - {8'h00, bw};
         d5 = {1'b0, rv[3:0]} - {1'b0, m_acc[3:0]} - {4'h0, bw};
      end
      @(posedge clk_in);
      op_in       <= op;
      dest_in     <= dst;
      literal_in  <= lit;
      reg_data_in <= rv;
      addr_in     <= ad;
      @(posedge clk_in);
      op_in <= rssd_pkg::OP_NONE;
      #1;
      if (op == rssd_pkg::OP_ROTATE)
      begin
         res = {m_c, rv[7:1]};
         m_c = rv[0];
      end
      else
      begin
         res  = d9[7:0];
         m_c  = ~d9[8];
         m_dc = ~d5[4];
         m_z  = (res == 8'h00);
      end
      we = (op != rssd_pkg::OP_LITSUB) && (dst == rssd_pkg::DEST_REG);
      if (!we)
         m_acc = res;
      check(acc_out, m_acc);
      check(carry_out, m_c);
      check(nibble_carry_out, m_dc);
      check(zero_out, m_z);
      check(reg_we_out, we);
      if (we)
      begin
         check(reg_wdata_out, res);
         check(reg_addr_out, ad);
      end
   endtask : run_op

   initial
   begin
      #20000;
      n_errors++;
      give_verdict();
   end

   initial
   begin
      repeat (16) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      #1;
      check(timeout_flag_out, rssd_pkg::RST_TIMEOUT);
      check(power_down_flag_out, rssd_pkg::RST_PWRDOWN);
      check(acc_out, rssd_pkg::RST_ACC);
      check(osc_run_out, 1'b1);
      // through the table
      for (int i = 0; i < 16; i++)
         run_op(t_op[i], t_dst[i], t_lit[i], t_reg[i], 7'(i + 3));
      // run the prescaler past one rollover so both clears are visible
      @(posedge clk_in);
      op_in <= rssd_pkg::OP_WDTTCK;
      repeat (300) @(posedge clk_in);
      op_in <= rssd_pkg::OP_SLEEP;
      #1;
      check(watchdog_counter_out, 8'h01);
      check(prescaler_out, 8'h2c);
      @(posedge clk_in);
      op_in <= rssd_pkg::OP_NONE;
      #1;
      check(timeout_flag_out, 1'b1);
      check(power_down_flag_out, 1'b0);
      check(watchdog_counter_out, 8'h00);
      check(prescaler_out, 8'h00);
      check(sleeping_out, 1'b1);
      check(osc_run_out, 1'b1);
      @(posedge clk_in);
      op_in       <= rssd_pkg::OP_REGSUB;
      dest_in     <= rssd_pkg::DEST_REG;
      reg_data_in <= 8'h55;
      #1;
      check(osc_run_out, 1'b0);
      @(posedge clk_in);
      op_in <= rssd_pkg::OP_NONE;
      #1;
      check(reg_we_out, 1'b0);
      check(acc_out, m_acc);
      check(nibble_carry_out, m_dc);
      // wake passes two flops, so the core resumes on the third edge
      @(posedge clk_in);
      wake_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1;
      check(sleeping_out, 1'b1);
      @(posedge clk_in);
      #1;
      check(sleeping_out, 1'b0);
      check(osc_run_out, 1'b1);
      @(posedge clk_in);
      wake_in <= 1'b0;
      run_op(rssd_pkg::OP_ROTATE, rssd_pkg::DEST_REG, 8'h00, 8'h80, 7'h7f);
      give_verdict();
   end
endmodule : rssd_datapath_bench
